// *** rtl/ahs_edge.sv ***
// Purpose: rising-edge and falling-edge pulses of the axis inputs
// Assumes: inputs already synchronous to clk
// Notes: one register stage holds the last sample; pulses are combinational, in the cycle the input changes
`timescale 1ns/1ps
module ahs_edge #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // levels in, pulses out
    input wire logic [WIDTH-1:0] lvl,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } ahs_edge_type;

    ahs_edge_type e_q, e_d;

    // ************************************************
    // previous sample
    // ************************************************
    always_comb begin
        e_d.prev = lvl;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            e_q <= '0;
        else
            e_q <= e_d;
    end

    assign rise = lvl & ~e_q.prev;
    assign fall = ~lvl & e_q.prev;
endmodule : ahs_edge

// *** rtl/ahs_pkg.sv ***
// Purpose: constants and types shared by the axis homing sequencer
// Assumes: one clock, positions in signed counts, speeds in mm/min codes
// Notes: search mode codes follow the origin search mode selector
package ahs_pkg;
    // ************************************************
    // mode codes and limits
    // ************************************************
    localparam logic [4:0] AHS_MODE_HERE = 5'h00;
    localparam logic [4:0] AHS_MODE_REV_Z = 5'h01;
    localparam logic [4:0] AHS_MODE_PASS_Z = 5'h02;
    localparam logic [4:0] AHS_MODE_OT = 5'h04;
    localparam logic [4:0] AHS_MODE_DOG = 5'h05;
    localparam logic [4:0] AHS_MODE_MAX = 5'h11;
    localparam logic [31:0] AHS_OFFSET_RST = 32'h0000_0000;
    localparam logic [13:0] AHS_SPEED1_RST = 14'h07d0;
    localparam logic [13:0] AHS_SPEED1_MAX = 14'h2710;
    localparam logic [10:0] AHS_PROT_RST = 11'h014;
    localparam logic [10:0] AHS_PROT_MIN = 11'h001;
    localparam logic [10:0] AHS_PROT_MAX = 11'h7d0;
    // ************************************************
    // status register bits (read clears)
    // ************************************************
    localparam int AHS_ST_DONE = 0;
    localparam int AHS_ST_ALARM = 1;
    localparam int AHS_ST_Z = 2;
    localparam int AHS_ST_BITS = 3;
    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [3:0] AHS_R_CTRL = 4'h0;
    localparam logic [3:0] AHS_R_OFFSET = 4'h1;
    localparam logic [3:0] AHS_R_SPEED1 = 4'h2;
    localparam logic [3:0] AHS_R_PROT = 4'h3;
    localparam logic [3:0] AHS_R_STATUS = 4'h4;
    localparam logic [3:0] AHS_R_MASK = 4'h5;
    localparam logic [3:0] AHS_R_POS = 4'h6;
    localparam logic [3:0] AHS_R_STATE = 4'h7;
    localparam logic [3:0] AHS_R_TURN = 4'h8;
    // ctrl field positions
    localparam int AHS_C_MODE = 0;
    localparam int AHS_C_DIR = 5;
    localparam int AHS_C_BLOCK = 6;
    localparam int AHS_C_ABS = 7;
    localparam int AHS_C_RETZ = 8;
    localparam int AHS_C_ROT = 9;
    localparam int AHS_C_SYNC = 10;
    localparam int AHS_C_INDIV = 11;
    localparam int AHS_C_START = 12;
    localparam int AHS_C_ABORT = 13;
    localparam logic [11:0] AHS_CTRL_RST = 12'h121;

    typedef enum logic [3:0] {
        AHS_IDLE, AHS_SEEK, AHS_LEAVE, AHS_SEEKZ, AHS_DECEL, AHS_MOVE, AHS_DONE, AHS_ALARM
    } ahs_state_type;

    // clamp a value into [lo, hi]
    function automatic logic [13:0] ahs_clamp(input logic [31:0] v, input logic [13:0] lo,
                                              input logic [13:0] hi);
        if (v < {18'h0, lo})
            return lo;
        else if (v > {18'h0, hi})
            return hi;
        else
            return v[13:0];
    endfunction : ahs_clamp
endpackage : ahs_pkg

// *** rtl/ahs_regs.sv ***
// Purpose: register port slave for the homing sequencer
// Assumes: strobes are one cycle, never together
// Notes: read data stand one cycle after the read strobe
`timescale 1ns/1ps
module ahs_regs (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // state seen by software
    input wire logic [31:0] pos,
    input wire logic [3:0] state,
    input wire logic [ahs_pkg::AHS_ST_BITS-1:0] events,
    // settings
    output logic [11:0] ctrl,
    output logic start_p,
    output logic abort_p,
    output logic [31:0] offset,
    output logic [13:0] speed1,
    output logic [10:0] prot,
    output logic [31:0] turn,
    output logic irq
);
    import ahs_pkg::*;

    typedef struct packed {
        logic [11:0] ctrl;
        logic start;
        logic abort;
        logic [31:0] offset;
        logic [13:0] speed1;
        logic [10:0] prot;
        logic [31:0] turn;
        logic [AHS_ST_BITS-1:0] status;
        logic [AHS_ST_BITS-1:0] mask;
        logic [31:0] rdata;
        logic irq;
    } ahs_regs_type;

    ahs_regs_type r_q, r_d;
    logic [13:0] pclamp;

    // ************************************************
    // decode, sticky status, read mux
    // ************************************************
    always_comb begin
        r_d = r_q;
        r_d.start = 1'b0;
        r_d.abort = 1'b0;
        r_d.rdata = 32'h0;
        pclamp = ahs_clamp(wdata, {3'h0, AHS_PROT_MIN}, {3'h0, AHS_PROT_MAX});
        if (wr) begin
            unique case (addr)
                AHS_R_CTRL: begin
                    // out-of-range mode is refused, keeps the old one
                    if (wdata[4:0] <= AHS_MODE_MAX)
                        r_d.ctrl = wdata[11:0];
                    else
                        r_d.ctrl = {wdata[11:5], r_q.ctrl[4:0]};
                    r_d.start = wdata[AHS_C_START];
                    r_d.abort = wdata[AHS_C_ABORT];
                end
                AHS_R_OFFSET: r_d.offset = wdata;
                AHS_R_SPEED1: r_d.speed1 = ahs_clamp(wdata, 14'h0, AHS_SPEED1_MAX);
                AHS_R_PROT: r_d.prot = pclamp[10:0];
                AHS_R_MASK: r_d.mask = wdata[AHS_ST_BITS-1:0];
                AHS_R_TURN: r_d.turn = wdata;
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                AHS_R_CTRL: r_d.rdata = {20'h0, r_q.ctrl};
                AHS_R_OFFSET: r_d.rdata = r_q.offset;
                AHS_R_SPEED1: r_d.rdata = {18'h0, r_q.speed1};
                AHS_R_PROT: r_d.rdata = {21'h0, r_q.prot};
                AHS_R_STATUS: r_d.rdata = {29'h0, r_q.status};
                AHS_R_MASK: r_d.rdata = {29'h0, r_q.mask};
                AHS_R_POS: r_d.rdata = pos;
                AHS_R_STATE: r_d.rdata = {28'h0, state};
                AHS_R_TURN: r_d.rdata = r_q.turn;
                default: r_d.rdata = 32'h0; // unmapped reads zero
            endcase
        end
        // read clears, a new event in the same cycle wins
        if (rd && addr == AHS_R_STATUS)
            r_d.status = events;
        else
            r_d.status = r_q.status | events;
        r_d.irq = |(r_d.status & r_d.mask);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= '{ctrl: AHS_CTRL_RST, offset: AHS_OFFSET_RST, speed1: AHS_SPEED1_RST,
                     prot: AHS_PROT_RST, turn: 32'h0000_0000, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign ctrl = r_q.ctrl;
    assign start_p = r_q.start;
    assign abort_p = r_q.abort;
    assign offset = r_q.offset;
    assign speed1 = r_q.speed1;
    assign prot = r_q.prot;
    assign turn = r_q.turn;
    assign rdata = r_q.rdata;
    assign irq = r_q.irq;
endmodule : ahs_regs

// *** rtl/axis_homing_sequencer.sv ***
// Purpose: homing sequencer for one axis or a master/slave pair
// Assumes: sensor, limit, Z and position inputs are synchronous to clk
// Notes: motion is commanded as direction, speed code and run; drive ramps itself
`timescale 1ns/1ps
module axis_homing_sequencer #(
    parameter int POS_W = 32,
    parameter int UNIT_CU = 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    // axis feedback
    input wire logic home_sensor,
    input wire logic pos_limit,
    input wire logic z_pulse,
    input wire logic stopped,
    input wire logic [POS_W-1:0] position,
    // drive command
    output logic run,
    output logic dir_pos,
    output logic [13:0] speed,
    output logic speed_z,
    output logic move_rel,
    output logic [POS_W-1:0] move_dist,
    output logic set_origin,
    output logic [POS_W-1:0] origin_pos,
    // sync control
    output logic sync_joint,
    output logic sync_protect,
    // result
    output logic done,
    output logic alarm
);
    import ahs_pkg::*;

    logic [11:0] ctrl;
    logic start_p, abort_p;
    logic [31:0] offset, turn;
    logic [13:0] speed1;
    logic [10:0] prot;
    logic [2:0] rise, fall;

    typedef struct packed {
        ahs_state_type st;
        logic [POS_W-1:0] start_pos;
        logic [POS_W-1:0] block_pos;
        logic run;
        logic dir_pos;
        logic [13:0] speed;
        logic speed_z;
        logic move_rel;
        logic [POS_W-1:0] move_dist;
        logic set_origin;
        logic [POS_W-1:0] origin_pos;
        logic sync_joint;
        logic sync_protect;
        logic done;
        logic alarm;
        logic [AHS_ST_BITS-1:0] ev;
    } ahs_core_type;

    ahs_core_type c_q, c_d;

    // ************************************************
    // register slave and edge detection
    // ************************************************
    ahs_regs u_regs (
        .clk(clk),
        .arst_n(arst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .pos(position),
        .state({1'b0, c_q.st[2:0]}),
        .events(c_q.ev),
        .ctrl(ctrl),
        .start_p(start_p),
        .abort_p(abort_p),
        .offset(offset),
        .speed1(speed1),
        .prot(prot),
        .turn(turn),
        .irq(irq)
    );

    ahs_edge #(
        .WIDTH(3)
    ) u_edge (
        .clk(clk),
        .arst_n(arst_n),
        .lvl({z_pulse, pos_limit, home_sensor}),
        .rise(rise),
        .fall(fall)
    );

    // distance magnitude between two positions
    function automatic logic [POS_W-1:0] ahs_dist(input logic [POS_W-1:0] a,
                                                  input logic [POS_W-1:0] b);
        logic [POS_W-1:0] d;
        d = a - b;
        return d[POS_W-1] ? (~d + 1'b1) : d;
    endfunction : ahs_dist

    logic [4:0] mode;
    logic home_rise, z_rise, home_fall;
    logic [POS_W-1:0] prot_cu;
    logic [POS_W-1:0] trav;
    logic [POS_W-1:0] rest;

    assign mode = ctrl[AHS_C_MODE +: 5];
    // overtravel mode swaps the limit in as the home sensor
    assign home_rise = (mode == AHS_MODE_OT) ? rise[1] : rise[0];
    assign home_fall = fall[0];
    assign z_rise = rise[2];
    assign prot_cu = POS_W'(prot) * POS_W'(UNIT_CU);
    assign trav = ahs_dist(position, c_q.start_pos);
    // remaining angle within one turn; turn of zero disables reduction
    assign rest = (turn == 32'h0) ? trav : (trav % POS_W'(turn));

    // ************************************************
    // homing state machine
    // ************************************************
    always_comb begin
        c_d = c_q;
        c_d.set_origin = 1'b0;
        c_d.move_rel = 1'b0;
        c_d.ev = '0;
        c_d.sync_joint = ctrl[AHS_C_SYNC] & ~ctrl[AHS_C_INDIV];
        c_d.sync_protect = ctrl[AHS_C_SYNC]; // stays on in both options
        unique case (c_q.st)
            AHS_IDLE: begin
                if (start_p) begin
                    c_d.done = 1'b0;
                    c_d.alarm = 1'b0;
                    c_d.start_pos = position;
                    c_d.block_pos = position;
                    if (mode == AHS_MODE_HERE) begin
                        c_d.set_origin = 1'b1; // no motion
                        c_d.origin_pos = position;
                        c_d.st = AHS_DONE;
                    end else if (ctrl[AHS_C_ROT]) begin
                        c_d.run = 1'b1;
                        c_d.move_rel = 1'b1;
                        c_d.speed = speed1;
                        c_d.speed_z = 1'b0;
                        c_d.dir_pos = ctrl[AHS_C_DIR];
                        // single-turn moves only the residue, absolute the whole way
                        c_d.move_dist = ctrl[AHS_C_ABS] ? trav : rest;
                        c_d.st = AHS_MOVE;
                    end else begin
                        c_d.run = 1'b1;
                        c_d.dir_pos = ctrl[AHS_C_DIR];
                        c_d.speed = speed1;
                        c_d.speed_z = 1'b0;
                        c_d.st = AHS_SEEK;
                    end
                end
            end
            AHS_SEEK: begin
                if (home_rise) begin
                    c_d.block_pos = position;
                    c_d.speed_z = 1'b1;
                    if (mode == AHS_MODE_PASS_Z) begin
                        c_d.st = AHS_LEAVE; // same direction
                    end else if (mode == AHS_MODE_DOG) begin
                        c_d.st = AHS_LEAVE; // leave the dog first
                    end else begin
                        c_d.dir_pos = ~c_q.dir_pos; // reverse
                        c_d.st = AHS_SEEKZ;
                    end
                end else if (ctrl[AHS_C_BLOCK] && ahs_dist(position, c_q.block_pos) > prot_cu) begin
                    c_d.alarm = 1'b1;
                    c_d.run = 1'b0; // halt in the same cycle the alarm shows
                    c_d.st = AHS_ALARM;
                end
            end
            AHS_LEAVE: begin
                if (home_fall) begin
                    if (mode == AHS_MODE_DOG) begin
                        c_d.dir_pos = ~c_q.dir_pos;
                        c_d.run = 1'b0;
                        c_d.st = AHS_DECEL;
                    end else begin
                        c_d.st = AHS_SEEKZ;
                    end
                end
            end
            AHS_SEEKZ: begin
                if (z_rise) begin
                    c_d.ev[AHS_ST_Z] = 1'b1;
                    c_d.run = 1'b0; // stop at once when AHS_C_RETZ is set
                    if (ctrl[AHS_C_RETZ]) begin
                        c_d.set_origin = 1'b1;
                        c_d.origin_pos = position;
                        c_d.st = AHS_DONE;
                    end else begin
                        c_d.run = 1'b1; // offset move
                        c_d.move_rel = 1'b1;
                        c_d.move_dist = POS_W'(offset);
                        c_d.st = AHS_MOVE;
                    end
                end
            end
            AHS_DECEL: begin
                if (stopped) begin
                    c_d.set_origin = 1'b1; // halt point, no Z
                    c_d.origin_pos = position;
                    c_d.st = AHS_DONE;
                end
            end
            AHS_MOVE: begin
                if (stopped && !c_q.move_rel) begin
                    c_d.run = 1'b0;
                    c_d.set_origin = 1'b1;
                    c_d.origin_pos = position;
                    c_d.st = AHS_DONE;
                end
            end
            AHS_DONE: begin
                c_d.run = 1'b0;
                c_d.done = 1'b1;
                c_d.ev[AHS_ST_DONE] = 1'b1;
                c_d.st = AHS_IDLE;
            end
            AHS_ALARM: begin
                c_d.run = 1'b0;
                c_d.ev[AHS_ST_ALARM] = 1'b1;
                c_d.st = AHS_IDLE;
            end
            default: c_d.st = AHS_IDLE;
        endcase
        // abort drops run and leaves done low; too late once the origin is set
        if (abort_p && c_q.st != AHS_IDLE && c_q.st != AHS_DONE) begin
            c_d.run = 1'b0;
            c_d.done = 1'b0;
            c_d.set_origin = 1'b0;
            c_d.st = AHS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            c_q <= '{st: AHS_IDLE, default: '0};
        else
            c_q <= c_d;
    end

    assign run = c_q.run;
    assign dir_pos = c_q.dir_pos;
    assign speed = c_q.speed;
    assign speed_z = c_q.speed_z;
    assign move_rel = c_q.move_rel;
    assign move_dist = c_q.move_dist;
    assign set_origin = c_q.set_origin;
    assign origin_pos = c_q.origin_pos;
    assign sync_joint = c_q.sync_joint;
    assign sync_protect = c_q.sync_protect;
    assign done = c_q.done;
    assign alarm = c_q.alarm;
endmodule : axis_homing_sequencer

// *** testbench/ahs_checker.sv ***
// Purpose: port checks for the homing sequencer
// Assumes: one clock domain
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module ahs_checker (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // watched ports
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic run,
    input wire logic [13:0] speed,
    input wire logic move_rel,
    input wire logic set_origin,
    input wire logic sync_joint,
    input wire logic sync_protect,
    input wire logic done,
    input wire logic alarm
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // motion stops at the origin, done follows one cycle on
    sequence s_finish;
        !run ##1 done;
    endsequence
    chk_origin_then_done: assert property (set_origin |-> s_finish)
        else $error("done did not follow the origin");
    chk_done_is_idle: assert property (done |-> !run && !alarm)
        else $error("done while moving or alarmed");
    chk_alarm_halts: assert property (alarm |-> !run)
        else $error("axis runs under alarm");
    chk_speed_cap: assert property (speed <= 14'h2710)
        else $error("search speed above its cap");
    chk_sync_pair: assert property (sync_joint |-> sync_protect)
        else $error("joint homing without protection");
    chk_move_pulse: assert property (move_rel |=> !move_rel)
        else $error("offset move request too long");
    chk_origin_pulse: assert property (set_origin |=> !set_origin)
        else $error("origin strobe too long");
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule : ahs_checker

bind axis_homing_sequencer ahs_checker ahs_checker_inst (.clk(clk), .arst_n(arst_n),
    .rd(rd), .rdata(rdata), .run(run), .speed(speed), .move_rel(move_rel),
    .set_origin(set_origin), .sync_joint(sync_joint), .sync_protect(sync_protect),
    .done(done), .alarm(alarm));

// *** testbench/ahs_drive_model.sv ***
// Purpose: drive, encoder and sensor model for the homing sequencer
// Assumes: one count of travel per cycle of motion
// Notes: sensors are pure functions of position
`timescale 1ns/1ps
module ahs_drive_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // command
    input wire logic run,
    input wire logic dir_pos,
    input wire logic move_rel,
    input wire logic [31:0] move_dist,
    // feedback
    output logic home_sensor,
    output logic pos_limit,
    output logic z_pulse,
    output logic stopped,
    output logic [31:0] position
);
    // ****
    // motion
    // ****
    localparam int HLO = 100;
    localparam int HHI = 120;
    int pos;
    int rem;
    logic rel;
    // an offset move wins over free running; after it the axis holds until run drops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos <= 0;
            rem <= 0;
            rel <= 1'b0;
        end else if (move_rel) begin
            rem <= int'(move_dist);
            rel <= 1'b1;
        end else if (rem != 0) begin
            pos <= pos + (rem > 0 ? 1 : -1);
            rem <= rem - (rem > 0 ? 1 : -1);
        end else if (!run) begin
            rel <= 1'b0;
        end else if (!rel) begin
            pos <= pos + (dir_pos ? 1 : -1);
        end
    end
    // a finished relative move counts as at rest even while run stays high
    assign stopped = rem == 0 && !move_rel && (!run || rel);
    assign home_sensor = pos >= HLO && pos <= HHI;
    assign pos_limit = pos >= 200;
    assign z_pulse = pos % 16 == 0;
    assign position = pos;
endmodule : ahs_drive_model

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the axis homing sequencer
// Assumes: drive model moves one count per cycle, z marks every 16 counts
// Notes: origin checks after motion allow three counts for the input edge lag
`timescale 1ns/1ps
module testbench;
    import ahs_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic irq, home_sensor, pos_limit, z_pulse, stopped, run, dir_pos, speed_z, move_rel;
    logic set_origin, sync_joint, sync_protect, done, alarm;
    logic [13:0] speed;
    logic [31:0] rdata, position, move_dist, origin_pos, org_seen, dist_seen, rv;
    logic [31:0] spd_seen, zs_seen, st_prev;
    logic [31:0] st_now = 32'h0;
    int miscompares = 0;
    int checked = 0;
    int seed = 86;
    int ran = 0;
    // ****
    // harness
    // ****
    axis_homing_sequencer #(.POS_W(32), .UNIT_CU(4)) axis_homing_sequencer_inst (.clk(clk),
        .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .home_sensor(home_sensor), .pos_limit(pos_limit), .z_pulse(z_pulse),
        .stopped(stopped), .position(position), .run(run), .dir_pos(dir_pos),
        .speed(speed), .speed_z(speed_z), .move_rel(move_rel), .move_dist(move_dist),
        .set_origin(set_origin), .origin_pos(origin_pos), .sync_joint(sync_joint),
        .sync_protect(sync_protect), .done(done), .alarm(alarm));
    ahs_drive_model ahs_drive_model_inst (.clk(clk), .arst_n(arst_n), .run(run),
        .dir_pos(dir_pos), .move_rel(move_rel), .move_dist(move_dist),
        .home_sensor(home_sensor), .pos_limit(pos_limit), .z_pulse(z_pulse),
        .stopped(stopped), .position(position));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // remember the last commands, strobes last one cycle only
    always @(posedge clk) begin
        if (set_origin === 1'b1) org_seen <= origin_pos;
        if (set_origin === 1'b1) zs_seen <= speed_z;
        if (move_rel === 1'b1) dist_seen <= move_dist;
        if (run === 1'b1 && speed_z === 1'b0) spd_seen <= speed;
        if (run === 1'b1) ran <= 1;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, int t);
        checked++;
        if (!(g === e || (t > 0 && (g - e + t <= 2 * t) === 1'b1))) begin
            miscompares++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
        chk(nm, e, rv, 0);
    endtask : rchk
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // old done may still stand for a few cycles after start
    task automatic home(input logic [31:0] ctl);
        st_prev = st_now;
        st_now = position;
        ran <= 0;
        wreg(AHS_R_CTRL, ctl | 32'h1000);
        settle();
        for (int i = 0; i < 3000 && done !== 1'b1 && alarm !== 1'b1; i++) #5;
        if (done !== 1'b1 && alarm !== 1'b1) begin
            miscompares++;
            $display("ERROR homing expected finish seen timeout");
            conclude();
        end
        settle();
        $display("test mode %0d ends", ctl[4:0]);
    endtask : home
    function automatic logic [31:0] cw(int m, bit d, bit b, bit z);
        return 32'(m) | 32'(d) << AHS_C_DIR | 32'(b) << AHS_C_BLOCK | 32'(z) << AHS_C_RETZ;
    endfunction : cw
    // first z mark below or above a sensor edge
    function automatic logic [31:0] zb(int p);
        return 32'((p - 1) / 16 * 16);
    endfunction : zb
    function automatic logic [31:0] za(int p);
        return 32'((p / 16 + 1) * 16);
    endfunction : za
    // travel between two start points, folded into one turn unless t is zero
    function automatic logic [31:0] td(logic [31:0] a, logic [31:0] b, logic [31:0] t);
        logic [31:0] d;
        d = (a > b) ? a - b : b - a;
        return (t == 0) ? d : d % t;
    endfunction : td
    // ****
    // scenarios
    // ****
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rchk("ctrl", AHS_R_CTRL, 32'h121);
        rchk("offset", AHS_R_OFFSET, 32'h0);
        rchk("speed1", AHS_R_SPEED1, 32'd2000);
        rchk("prot", AHS_R_PROT, 32'd20);
        rchk("unmapped", 4'h9, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rv = 32'($unsigned($random(seed)) % 10001);
            wreg(AHS_R_SPEED1, rv);
            rchk("speed1", AHS_R_SPEED1, rv);
        end
        wreg(AHS_R_SPEED1, 32'd20000);
        rchk("speed1 cap", AHS_R_SPEED1, 32'd10000);
        wreg(AHS_R_PROT, 32'd0);
        rchk("prot low", AHS_R_PROT, 32'd1);
        wreg(AHS_R_PROT, 32'd5000);
        rchk("prot high", AHS_R_PROT, 32'd2000);
        wreg(AHS_R_CTRL, 32'h12);
        rchk("bad mode", AHS_R_CTRL, 32'h1);
        wreg(AHS_R_PROT, 32'd1);
        home(cw(0, 0, 0, 1));
        chk("here origin", 0, org_seen, 0);
        chk("here motion", 0, ran, 0);
        chk("irq masked", 0, irq, 0);
        wreg(AHS_R_MASK, 32'h7);
        settle();
        chk("irq", 1, irq, 0);
        rchk("status", AHS_R_STATUS, 32'h1);
        settle();
        chk("irq cleared", 0, irq, 0);
        home(cw(1, 1, 0, 1));
        chk("reverse origin", zb(100), org_seen, 3);
        chk("search speed", 32'd10000, spd_seen, 0);
        chk("slow z", 1, zs_seen, 0);
        chk("no block alarm", 0, alarm, 0);
        rchk("status z", AHS_R_STATUS, 32'h5);
        home(cw(2, 1, 0, 1));
        chk("pass origin", za(121), org_seen, 3);
        home(cw(4, 1, 0, 1));
        chk("limit origin", zb(200), org_seen, 3);
        home(cw(5, 0, 0, 1));
        chk("dog origin", 99, org_seen, 3);
        wreg(AHS_R_OFFSET, 32'd5);
        home(cw(1, 1, 0, 0));
        chk("offset move", 5, dist_seen, 0);
        chk("machine origin", zb(100) + 5, org_seen, 3);
        wreg(AHS_R_CTRL, 32'h400);
        settle();
        chk("joint", 1, sync_joint, 0);
        chk("protect", 1, sync_protect, 0);
        wreg(AHS_R_CTRL, 32'hc00);
        settle();
        chk("alone", 0, sync_joint, 0);
        chk("alone protect", 1, sync_protect, 0);
        home(cw(1, 0, 1, 1));
        chk("alarm", 1, alarm, 0);
        chk("alarm done", 0, done, 0);
        chk("alarm run", 0, run, 0);
        wreg(AHS_R_TURN, 32'd4);
        home(cw(1, 1, 0, 1) | 32'h280);
        chk("abs move", td(st_now, st_prev, 0), dist_seen, 0);
        home(cw(1, 1, 0, 1) | 32'h200);
        chk("turn move", td(st_now, st_prev, 4), dist_seen, 0);
        conclude();
    end
endmodule : testbench
